// file: burst_ctrl_status.sv
// control registers, tone burst sequencer and status flags of the transceiver
// assumes a host strobe interface already in the reference clock domain and
// decoder events (digit valid, signal present) arriving asynchronously
// Operation
// - Second control bit 0 high disables tone-pulse mode, low enables it.
// - In pulse mode a transmit write gives one tone then equal pause, 51 ms.
// - Pause end sets transmit-empty and raises interrupt when enabled.
// - Call-progress mode doubles pulse and pause to 102 ms.
// - Without pulse mode the tone follows the tone output enable bit.
// - Diagnostic bit with DTMF mode makes the pin follow held-detect.
// - Single/dual bit high gives single tone, low gives dual tone.
// - Single tone chooses row or column by the column/row bit.
// - Column/row high selects column, low selects row, only in single mode.
// - Interrupt flag is set whenever transmit-empty or receive-full is set.
// - Interrupt flag clears after a host status read.
// - Transmit-empty sets only in pulse mode after the pause ends.
// - Transmit-empty clears on status read and stays clear outside pulse mode.
// - Receive-full sets on a valid digit and clears on status read.
// - Held-detect sets on valid absence of signal, clears on valid signal.
// - Control write with redirect bit routes the next control write to second.
// - Enabled interrupt in DTMF mode without the diagnostic bit pulls the open-drain pin low on events.
`timescale 1ns/1ps
module burst_ctrl_status
  import burst_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = BURST_CYCLES
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // host register access, one-cycle strobes
  input wire host_req_t ctrl_req,
  input wire logic tx_write,
  output logic [3:0] status_rdata,
  // decoder events from the receive path
  input wire logic digit_valid_raw,
  input wire logic signal_present_raw,
  input wire logic progress_square_raw,
  // tone generator steering
  output tone_ctrl_t tone_ctrl,
  // open-drain interrupt/progress pin, enable low drives low
  output logic interrupt_progress_pin_o,
  output logic interrupt_progress_pin_oe_b
);
  // host-visible registers and the one-shot redirect
  logic [3:0] first_control_reg_q;
  logic [3:0] second_control_reg_q;
  logic redirect_q;
  // status flags and the registered read data
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic [3:0] rdata_q;
  // burst sequencer
  burst_state_t state_q;
  burst_state_t state_d;
  // registered outputs and their next values
  tone_ctrl_t tone_q;
  tone_ctrl_t tone_d;
  logic pin_oe_b_q;
  logic pin_oe_b_d;
  // receive path: edge memory and validated levels; burst timer result
  logic digit_seen_q;
  logic [2:0] ev_level;
  logic timer_done;

  // refuse a burst count that the interval counter cannot hold when doubled
  //   the same limit is checked again inside the counter itself
  if (BASE_CYCLES < 1 || BASE_CYCLES >= (1 << CNT_W))
  begin
    $error("burst_ctrl_status: BASE_CYCLES out of range");
  end

  // decoded strobes and mode terms
  wire ctrl_wr = ctrl_req.sel && ctrl_req.wr;
  wire status_rd = ctrl_req.sel && ctrl_req.rd;
  wire pulse_mode = !second_control_reg_q[CB_PULSE_OFF];
  wire cp_mode = first_control_reg_q[CA_CP];
  wire irq_en = first_control_reg_q[CA_IRQ];
  wire diag_mode = second_control_reg_q[CB_DIAG];
  wire digit_rise = ev_level[0] && !digit_seen_q;
  wire burst_start = tx_write && pulse_mode;
  wire pause_end = (state_q == ST_PAUSE) && timer_done;
  wire timer_start = burst_start || ((state_q == ST_TONE) && timer_done);
  wire timer_stop = !pulse_mode;

  // synchronise the decoder levels
  pin_sync #(
    .WIDTH(3)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .raw({progress_square_raw, signal_present_raw, digit_valid_raw}),
    .level(ev_level)
  );

  // pulse and pause interval counter
  burst_timer #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .start(timer_start),
    .stop(timer_stop),
    .doubled(cp_mode),
    .done(timer_done)
  );

  // burst sequencer next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (burst_start)
          state_d = ST_TONE;
      end
      ST_TONE:
      begin
        if (timer_done)
          state_d = ST_PAUSE;
      end
      ST_PAUSE:
      begin
        if (timer_done)
          state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
    // leaving pulse mode aborts a burst at once
    // a transmit write during a burst starts it over from the tone phase
    if (!pulse_mode)
      state_d = ST_IDLE;
    else if (burst_start)
      state_d = ST_TONE;
  end

  // status flags: set wins over the read clear
  always_comb
  begin
    flags_d = flags_q;
    if (status_rd)
    begin
      flags_d[ST_TXE] = 1'b0;
      flags_d[ST_RXF] = 1'b0;
      flags_d[ST_IRQ] = 1'b0;
    end
    // sets follow the clear, so an event in the read cycle is kept
    if (pause_end && pulse_mode)
      flags_d[ST_TXE] = 1'b1;
    // outside pulse mode the empty flag is forced low whatever the timer did
    if (!pulse_mode)
      flags_d[ST_TXE] = 1'b0;
    if (digit_rise)
      flags_d[ST_RXF] = 1'b1;
    if ((pause_end && pulse_mode) || digit_rise)
      flags_d[ST_IRQ] = 1'b1;
    // held-detect tracks the validated signal level
    if (ev_level[1])
      flags_d[ST_HELD] = 1'b0;
    else
      flags_d[ST_HELD] = 1'b1;
  end

  // tone steering
  //   column is forced low unless a single tone is selected
  //   the pulse-mode gate looks at state_d so tone and state switch together
  always_comb
  begin
    tone_d.single = second_control_reg_q[CB_SINGLE];
    tone_d.column = second_control_reg_q[CB_SINGLE] && second_control_reg_q[CB_COLUMN];
    if (pulse_mode)
      tone_d.tone_on = first_control_reg_q[CA_TONE] && (state_d == ST_TONE);
    else
      tone_d.tone_on = first_control_reg_q[CA_TONE];
  end

  // open-drain pin: low enable pulls the line low
  //   call-progress mode passes the square wave when interrupts are enabled
  //   diagnostic mode shows held-detect, otherwise an enabled interrupt flag pulls low
  always_comb
  begin
    pin_oe_b_d = 1'b1;
    if (cp_mode)
    begin
      if (irq_en)
        pin_oe_b_d = ev_level[2];
    end
    else if (diag_mode)
      pin_oe_b_d = flags_d[ST_HELD];
    else if (irq_en)
      pin_oe_b_d = !flags_d[ST_IRQ];
  end

  // control register writes with one-shot redirect
  //   a write with the redirect bit set arms the next write for the second register
  //   that write disarms it, so later writes land in the first register again
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      first_control_reg_q <= CTRL_RST;
      second_control_reg_q <= CTRL_RST;
      redirect_q <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      if (redirect_q)
      begin
        second_control_reg_q <= ctrl_req.data;
        redirect_q <= 1'b0;
      end
      else
      begin
        first_control_reg_q <= ctrl_req.data;
        redirect_q <= ctrl_req.data[CA_REDIR];
      end
    end
  end

  // sequencer state, aborts and restarts are already folded into state_d
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // status flags
  //   set events beat the read clear inside flags_d
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flags_q <= FLAGS_RST;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  // read data register, loaded from flags_d so it never lags the flags
  //   a read in the strobe cycle therefore sees exactly the flags it clears
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata_q <= FLAGS_RST;
    end
    else
    begin
      rdata_q <= flags_d;
    end
  end

  // tone steering register
  //   the generator never sees the decode settle
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tone_q <= '0;
    end
    else
    begin
      tone_q <= tone_d;
    end
  end

  // pin enable register
  //   released during reset so the external pull-up holds the line high
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_oe_b_q <= 1'b1;
    end
    else
    begin
      pin_oe_b_q <= pin_oe_b_d;
    end
  end

  // previous validated digit level for the rising-edge detector
  //   reset low matches the idle decoder level, so no false digit follows reset
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      digit_seen_q <= 1'b0;
    end
    else
    begin
      digit_seen_q <= ev_level[0];
    end
  end

  assign status_rdata = rdata_q;
  assign tone_ctrl = tone_q;
  assign interrupt_progress_pin_o = 1'b0;
  assign interrupt_progress_pin_oe_b = pin_oe_b_q;
endmodule

// file: burst_ctrl_status_monitor.sv
// assertion checker for the tone burst control and status block
// assumes it is bound to burst_ctrl_status and sees only its ports
`timescale 1ns/1ps
module burst_ctrl_status_monitor
  import burst_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = BURST_CYCLES
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // watched ports
  input wire host_req_t ctrl_req,
  input wire logic tx_write,
  input wire logic [3:0] status_rdata,
  input wire logic digit_valid_raw,
  input wire logic signal_present_raw,
  input wire tone_ctrl_t tone_ctrl,
  input wire logic interrupt_progress_pin_o
);
  // host strobes
  wire logic ctl_wr = ctrl_req.sel & ctrl_req.wr;
  wire logic st_rd = ctrl_req.sel & ctrl_req.rd;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_pin_drain_only: assert property (interrupt_progress_pin_o == 1'b0)
    else $error("pin driven high");
  a_column_needs_single: assert property (tone_ctrl.column |-> tone_ctrl.single)
    else $error("column without single");
  a_irq_follows_flags: assert property ((status_rdata[ST_TXE] | status_rdata[ST_RXF])
    |-> ##[0:2] status_rdata[ST_IRQ])
    else $error("irq flag missing");
  a_read_clears_flags: assert property (st_rd |-> ##[1:2] (status_rdata[2:0] == 3'h0))
    else $error("flags kept after read");
  a_held_on_absence: assert property ($rose(status_rdata[ST_HELD]) |-> !signal_present_raw)
    else $error("held set with signal");
  a_rxf_on_digit: assert property ($rose(status_rdata[ST_RXF]) |-> digit_valid_raw)
    else $error("rx full without digit");
  a_txe_after_pause: assert property ($rose(status_rdata[ST_TXE])
    |-> $past(tone_ctrl.tone_on, 8) == 1'b0)
    else $error("empty flag before pause");
  a_tone_has_cause: assert property ($rose(tone_ctrl.tone_on) |-> $past(tx_write)
    || $past(tx_write, 2) || $past(ctl_wr, 2) || $past(ctl_wr, 3))
    else $error("tone without cause");
endmodule

// file: burst_ctrl_status_tb.sv
// self-checking bench for the tone burst control and status block
// assumes a shortened burst count and the host model on the bus
`timescale 1ns/1ps
module burst_ctrl_status_tb;
  import burst_pkg::*;
  localparam int N = 20;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic dv = 1'b0;
  logic sp = 1'b0;
  host_req_t req;
  logic txw;
  logic [3:0] st;
  tone_ctrl_t tc;
  logic oe_b;
  logic [3:0] rv;
  int miscompares = 0;
  int n_tests = 0;
  int t_on;
  int t_off;
  always #12.5 ref_clk = ~ref_clk;
  burst_ctrl_status #(.BASE_CYCLES(N)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .ctrl_req(req), .tx_write(txw), .status_rdata(st), .digit_valid_raw(dv),
    .signal_present_raw(sp), .progress_square_raw(1'b0), .tone_ctrl(tc),
    .interrupt_progress_pin_o(), .interrupt_progress_pin_oe_b(oe_b));
  burst_host_model i_host (.ref_clk(ref_clk), .status_rdata(st), .ctrl_req(req),
    .tx_write(txw));
  // compare four-bit values and lengths
  task automatic chk(input string w, input logic [3:0] e, input logic [3:0] g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chk_len(input string w, input int e, input int g);
    n_tests++;
    if (g < e - 1 || g > e + 5)
    begin
      miscompares++;
      $display("unexpected %s: expected %0d seen %0d", w, e, g);
    end
  endtask
  task automatic settle();
    repeat (6) @(negedge ref_clk);
  endtask
  // one burst: tone length and pause up to the empty flag
  task automatic burst(output int on, output int off);
    on = 0;
    off = 0;
    i_host.send_code();
    while (tc.tone_on === 1'b1 && on < 5 * N)
    begin
      @(negedge ref_clk);
      on++;
    end
    while (st[ST_TXE] !== 1'b1 && off < 5 * N)
    begin
      @(negedge ref_clk);
      off++;
    end
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (4000) @(posedge ref_clk);
    miscompares++;
    print_verdict();
  end
  // test sequence
  initial
  begin
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    settle();
    chk("reset flags", 4'h8, st);
    i_host.set_regs(4'h5, 4'h0);
    settle();
    chk("dual steering", 4'h0, {1'b0, tc});
    burst(t_on, t_off);
    chk_len("tone", N, t_on);
    chk_len("pause", N, t_off);
    settle();
    chk("ready pin", 4'h0, {3'h0, oe_b});
    i_host.status_read(rv);
    chk("ready flags", 4'hB, rv);
    settle();
    chk("read flags", 4'h8, st);
    chk("read pin", 4'h1, {3'h0, oe_b});
    i_host.ctrl_write(4'h3);
    burst(t_on, t_off);
    chk_len("cp tone", 2 * N, t_on);
    chk_len("cp pause", 2 * N, t_off);
    settle();
    chk("cp flags", 4'hB, st);
    i_host.set_regs(4'h1, 4'h1);
    settle();
    chk("steady tone", 4'h4, {1'b0, tc});
    chk("pulse off flags", 4'h9, st);
    i_host.status_read(rv);
    chk("pulse off read", 4'h9, rv);
    i_host.send_code();
    settle();
    chk("no empty", 4'h8, st);
    i_host.set_regs(4'h0, 4'hD);
    settle();
    chk("column", 4'h3, {1'b0, tc});
    i_host.set_regs(4'h0, 4'h5);
    settle();
    chk("row", 4'h2, {1'b0, tc});
    i_host.set_regs(4'h0, 4'h3);
    settle();
    chk("held pin", 4'h1, {3'h0, oe_b});
    sp = 1'b1;
    settle();
    chk("held clear", 4'h0, st);
    chk("present pin", 4'h0, {3'h0, oe_b});
    dv = 1'b1;
    settle();
    chk("digit", 4'h5, st);
    i_host.status_read(rv);
    settle();
    chk("digit read", 4'h0, st);
    sp = 1'b0;
    settle();
    chk("held again", 4'h8, st);
    chk("absent pin", 4'h1, {3'h0, oe_b});
    print_verdict();
  end
endmodule
bind burst_ctrl_status burst_ctrl_status_monitor #(.BASE_CYCLES(BASE_CYCLES)) i_mon (
  .ref_clk(ref_clk), .rst_b(rst_b), .ctrl_req(ctrl_req), .tx_write(tx_write),
  .status_rdata(status_rdata), .digit_valid_raw(digit_valid_raw),
  .signal_present_raw(signal_present_raw), .tone_ctrl(tone_ctrl),
  .interrupt_progress_pin_o(interrupt_progress_pin_o));

// file: burst_host_model.sv
// host bus model: control writes, status reads, transmit writes
// assumes one-cycle strobes launched on the falling clock edge
`timescale 1ns/1ps
module burst_host_model
  import burst_pkg::*;
(
  // clock and read data
  input wire logic ref_clk,
  input wire logic [3:0] status_rdata,
  // requests
  output host_req_t ctrl_req,
  output logic tx_write
);
  // idle bus
  initial
  begin
    ctrl_req = '0;
    tx_write = 1'b0;
  end
  // one control write, released data inverted
  task automatic ctrl_write(input logic [3:0] d);
    @(negedge ref_clk);
    ctrl_req = {3'b110, d};
    @(negedge ref_clk);
    ctrl_req = {3'b000, ~d};
  endtask
  // first register with redirect, then second register
  task automatic set_regs(input logic [3:0] a, input logic [3:0] b);
    ctrl_write(a | 4'h8);
    ctrl_write(b);
  endtask
  // status read, value taken in the strobe cycle
  task automatic status_read(output logic [3:0] v);
    @(negedge ref_clk);
    ctrl_req = 7'h50;
    v = status_rdata;
    @(negedge ref_clk);
    ctrl_req = '0;
  endtask
  // transmit data write strobe
  task automatic send_code();
    @(negedge ref_clk);
    tx_write = 1'b1;
    @(negedge ref_clk);
    tx_write = 1'b0;
  endtask
endmodule

// file: burst_pkg.sv
// shared constants and carrier types for the tone burst control and status block
// assumes a 40 MHz reference clock and the documented four-bit register layouts
package burst_pkg;
  // clock rate and burst timing
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned BURST_MS = 51;
  localparam int unsigned BURST_CYCLES = (CLK_HZ / 1000) * BURST_MS;
  localparam int unsigned CNT_W = 23;
  // first control register fields
  localparam int unsigned CA_TONE = 0;
  localparam int unsigned CA_CP = 1;
  localparam int unsigned CA_IRQ = 2;
  localparam int unsigned CA_REDIR = 3;
  // second control register fields
  localparam int unsigned CB_PULSE_OFF = 0;
  localparam int unsigned CB_DIAG = 1;
  localparam int unsigned CB_SINGLE = 2;
  localparam int unsigned CB_COLUMN = 3;
  // status register fields
  localparam int unsigned ST_IRQ = 0;
  localparam int unsigned ST_TXE = 1;
  localparam int unsigned ST_RXF = 2;
  localparam int unsigned ST_HELD = 3;
  // reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // burst sequencer states, gray from idle to tone to pause, both bits change from pause back to idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TONE = 2'b01,
    ST_PAUSE = 2'b11
  } burst_state_t;

  // host bus request
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [3:0] data;
  } host_req_t;

  // tone generator steering
  typedef struct packed {
    logic tone_on;
    logic single;
    logic column;
  } tone_ctrl_t;
endpackage

// file: burst_timer.sv
// pulse and pause interval counter with a one-cycle done pulse
// assumes start arrives only while the counter is idle or restarting
`timescale 1ns/1ps
module burst_timer
  import burst_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = BURST_CYCLES
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // control
  input wire logic start,
  input wire logic stop,
  input wire logic doubled,
  // result
  output logic done
);
  localparam logic [CNT_W:0] BASE = (CNT_W + 1)'(BASE_CYCLES);

  // refuse a count that the doubled terminal value would overflow
  if (BASE_CYCLES < 1 || BASE_CYCLES >= (1 << CNT_W))
  begin
    $error("burst_timer: BASE_CYCLES out of range");
  end

  logic [CNT_W:0] cnt_q;
  logic [CNT_W:0] cnt_d;
  logic run_q;
  logic done_q;
  logic [CNT_W:0] limit;
  wire at_end;

  // terminal count doubles in call-progress mode
  assign limit = doubled ? (BASE << 1) : BASE;
  assign at_end = run_q && (cnt_q >= limit - (CNT_W + 1)'(1));
  assign cnt_d = start ? '0 : (cnt_q + (CNT_W + 1)'(1));

  // counting process
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= at_end && !start && !stop;
      if (stop)
      begin
        run_q <= 1'b0;
        cnt_q <= '0;
      end
      else if (start)
      begin
        run_q <= 1'b1;
        cnt_q <= '0;
      end
      else if (at_end)
      begin
        run_q <= 1'b0;
      end
      else if (run_q)
      begin
        cnt_q <= cnt_d;
      end
    end
  end

  assign done = done_q;
endmodule

// file: pin_sync.sv
// three-stage synchroniser with agreement of stages two and three
// assumes an asynchronous input and one clock domain
`timescale 1ns/1ps
module pin_sync
  import burst_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // raw and filtered levels
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_q;

  // shift chain, level moves only when stage two and three agree
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_q <= '0;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < WIDTH; i++)
      begin
        if (s2_q[i] == s3_q[i])
        begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign level = level_q;
endmodule
